// ### tb/pmw_core_model.sv
// ****************************************************************
// Processor core and watchdog seen from the power controller
// ****************************************************************
module pmw_core_model (
    input wire logic ref_clk_i,
    input wire logic run_i,
    output pmw_pkg::pmw_core_s core_o,
    output logic wdt_overflow_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        core_o = '0;
        wdt_overflow_o = 1'b0;
    end

    // Pulse 0 is halt, 1 is clear-watchdog, 2 is a watchdog overflow.
    // Instructions only issue while the core runs, so those two wait.
    task automatic pulse(input int which);
        @(posedge ref_clk_i);
        while (which < 2 && run_i !== 1'b1)
            @(posedge ref_clk_i);
        core_o.halt <= (which == 0);
        core_o.clr_wdt <= (which == 1);
        wdt_overflow_o <= (which == 2);
        @(posedge ref_clk_i);
        core_o.halt <= 1'b0;
        core_o.clr_wdt <= 1'b0;
        wdt_overflow_o <= 1'b0;
    endtask

    task automatic set_stack(input logic full);
        @(posedge ref_clk_i);
        core_o.stack_full <= full;
    endtask
endmodule

// ### tb/tb_power_mode_wakeup_control.sv
module tb_power_mode_wakeup_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RSTD = 20;
    localparam int LIMIT = 20000;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ext_resetn_i = 1'b1;
    logic [1:0] osc_cfg = 2'h3;
    logic [1:0] wdt_src = 2'h0;
    logic rc_dis = 1'b0;
    logic [7:0] port_a = 8'hFF;
    logic [3:0] irq_req = 4'h0;
    logic [3:0] irq_en = 4'h0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    pmw_pkg::pmw_core_s core;
    pmw_pkg::pmw_osc_s osc;
    logic ovf, run, crst, pcsp, wclr, wrun, isvc;
    int miscompares = 0;
    int n_checks = 0;
    int seed = 35;
    int cyc = 0;
    int n_wclr = 0;
    int n_pcsp = 0;
    int n_isvc = 0;

    pmw_power_ctrl #(.RSTD_CYCLES(RSTD)) i_pmw_power_ctrl (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .ext_resetn_i(ext_resetn_i), .osc_cfg_i(osc_cfg),
        .wdt_src_i(wdt_src), .slow_rc_disable_i(rc_dis), .core_i(core),
        .wdt_overflow_i(ovf), .port_a_i(port_a), .irq_req_i(irq_req),
        .irq_en_i(irq_en), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(wreq), .osc_o(osc),
        .run_o(run), .core_reset_o(crst), .pc_sp_reset_o(pcsp),
        .wdt_clear_o(wclr), .wdt_run_o(wrun), .irq_service_o(isvc));

    pmw_core_model i_pmw_core_model (.ref_clk_i(ref_clk_i), .run_i(run),
        .core_o(core), .wdt_overflow_o(ovf));

    // ****************************************************************
    // Clock, pulse counters, watchdog on the run itself
    // ****************************************************************
    initial
        forever #25 ref_clk_i = ~ref_clk_i;

    // One-cycle pulses are counted here so no scenario can miss one.
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        n_wclr <= n_wclr + int'(wclr === 1'b1);
        n_pcsp <= n_pcsp + int'(pcsp === 1'b1);
        n_isvc <= n_isvc + int'(isvc === 1'b1);
        if (cyc == LIMIT)
        begin
            miscompares = miscompares + 1;
            summarize();
        end
    end

    task automatic summarize();
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk_i);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            n = n + 1;
        end
        while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        check("bus answer", 32'(n), 32'h2);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check("read data", q, exp);
    endtask

    task automatic wait_run(input int exp);
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            #1;
            n = n + 1;
        end
        while (run !== 1'b1 && n < 400);
        check("cycles to run", 32'(n), 32'(exp));
    endtask

    function automatic int start_cyc(input logic [1:0] cfg, input logic sel);
        return (cfg == 2'h0 || (cfg == 2'h3 && sel)) ? 128 : 2;
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] v;
        logic [1:0] cfg;
        logic [7:0] pin;
        logic [3:0] p, q;
        logic sel, lp, x3;
        int k, w0, s0, i0;
        repeat (8) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        wait_run(RSTD + 128);
        check("core reset", 32'(crst), 32'h0);
        rdchk(pmw_pkg::CONTROL_REG_ZERO_OFS, 32'h0);
        rdchk(pmw_pkg::STATUS_OFS, 32'h0);
        rdchk(pmw_pkg::MODE_OFS, 32'h1);
        bus(1'b1, 4'h2, 32'hFF, v);
        rdchk(4'h2, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            cfg = 2'(i / 2);
            sel = i[0];
            k = i % 4;
            x3 = (cfg == 2'h3);
            lp = 1'($random(seed));
            pin = 8'h1 << ($unsigned($random(seed)) % 8);
            q = 4'h1 << ($unsigned($random(seed)) % 4);
            p = {q[2:0], q[3]};
            @(posedge ref_clk_i);
            osc_cfg <= cfg;
            wdt_src <= 2'($unsigned($random(seed)) % 3);
            rc_dis <= 1'($random(seed));
            bus(1'b1, pmw_pkg::CONTROL_REG_ZERO_OFS,
                {30'h0, lp, sel}, v);
            rdchk(pmw_pkg::CONTROL_REG_ZERO_OFS, {30'h0, lp, sel});
            bus(1'b1, pmw_pkg::PORT_A_WAKE_ENABLE_OFS, {24'h0, pin}, v);
            #1;
            check("slow clk", 32'(osc.sys_clk_slow), 32'(x3 && sel));
            check("fast osc", 32'(osc.fast_osc_run), 32'(!x3 || !sel));
            check("slow xtal", 32'(osc.slow_xtal_run), 32'(x3));
            if (x3)
                check("low power", 32'(osc.xtal_low_power), 32'(lp));
            @(posedge ref_clk_i);
            irq_req <= (k >= 2) ? p : 4'h0;
            irq_en <= q;
            i_pmw_core_model.set_stack(k == 3);
            w0 = n_wclr;
            s0 = n_pcsp;
            i0 = n_isvc;
            i_pmw_core_model.pulse(0);
            #1;
            check("run in halt", 32'(run), 32'h0);
            check("fast halted", 32'(osc.fast_osc_run), 32'h0);
            check("xtal halted", 32'(osc.slow_xtal_run), 32'(x3));
            check("slow rc", 32'(osc.slow_rc_run), 32'(!rc_dis));
            check("wdt run", 32'(wrun), 32'(wdt_src != 2'h2));
            v = {26'h0, x3 && sel, x3 ? 5'h02 : 5'h04};
            rdchk(pmw_pkg::MODE_OFS, v);
            rdchk(pmw_pkg::STATUS_OFS, 32'h1);
            check("wdt clear", 32'(n_wclr - w0), 32'h1);
            // Other pins fall and, for k of 2 and 3, an old request stays pending: no wake.
            @(posedge ref_clk_i);
            port_a <= pin;
            repeat (4) @(posedge ref_clk_i);
            #1;
            check("no wake", 32'(run), 32'h0);
            if (k == 1)
                i_pmw_core_model.pulse(2);
            else
            begin
                @(posedge ref_clk_i);
                port_a <= (k == 0) ? 8'h00 : pin;
                irq_req <= (k >= 2) ? (p | q) : 4'h0;
            end
            wait_run(start_cyc(cfg, sel) + ((k == 1) ? 0 : 1));
            rdchk(pmw_pkg::STATUS_OFS, (k == 1) ? 32'h3 : 32'h1);
            check("pc sp reset", 32'(n_pcsp - s0), 32'(k == 1));
            check("irq service", 32'(n_isvc - i0), 32'(k == 2));
            @(posedge ref_clk_i);
            port_a <= 8'hFF;
            irq_req <= 4'h0;
            i_pmw_core_model.pulse(1);
            rdchk(pmw_pkg::STATUS_OFS, (k == 1) ? 32'h2 : 32'h0);
        end
        i_pmw_core_model.pulse(0);
        @(posedge ref_clk_i);
        ext_resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("ext reset", 32'(crst), 32'h1);
        @(posedge ref_clk_i);
        ext_resetn_i <= 1'b1;
        wait_run(RSTD + 128);
        rdchk(pmw_pkg::STATUS_OFS, 32'h1);
        summarize();
    end
endmodule

// ### verilog/pmw_pkg.sv
package pmw_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RESET_DELAY_NS = 50000000;
    // A least time, so the division rounds up.
    localparam int unsigned RESET_DELAY_CYC =
        (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SHORT_STARTUP_CYC = 2;
    localparam int unsigned LONG_STARTUP_CYC = 128;
    localparam int unsigned CNT_W = 20;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int unsigned PORT_W = 8;
    localparam int unsigned IRQ_NUM = 4;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // ****************************************************************
    // Register map, byte addresses and fields
    // ****************************************************************
    localparam logic [3:0] CONTROL_REG_ZERO_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] PORT_A_WAKE_ENABLE_OFS = 4'h8;
    localparam logic [3:0] MODE_OFS = 4'hC;
    localparam int unsigned SYS_CLK_SEL_BIT = 0;
    localparam int unsigned XTAL_LP_SEL_BIT = 1;
    localparam int unsigned PDF_BIT = 0;
    localparam int unsigned TMO_BIT = 1;
    localparam int unsigned MODE_SLOW_BIT = 5;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [4:0] {
        MODE_RUN = 5'h01,
        MODE_IDLE = 5'h02,
        MODE_SLEEP = 5'h04,
        MODE_WAKE = 5'h08,
        MODE_RSTD = 5'h10
    } pmw_mode_e;

    typedef enum logic [1:0] {
        CFG_FAST_XTAL = 2'h0,
        CFG_EXT_RC = 2'h1,
        CFG_FAST_RC = 2'h2,
        CFG_FAST_RC_SLOW_XTAL = 2'h3
    } pmw_osc_cfg_e;

    typedef enum logic [1:0] {
        WDT_SRC_SLOW_RC = 2'h0,
        WDT_SRC_SLOW_XTAL = 2'h1,
        WDT_SRC_SYS = 2'h2
    } pmw_wdt_src_e;

    typedef struct packed {
        logic halt;
        logic clr_wdt;
        logic stack_full;
    } pmw_core_s;

    typedef struct packed {
        logic fast_osc_run;
        logic slow_xtal_run;
        logic slow_rc_run;
        logic sys_clk_slow;
        logic xtal_low_power;
    } pmw_osc_s;

    typedef struct packed {
        pmw_mode_e mode;
        logic [CNT_W-1:0] cnt;
        logic clk_sel;
        logic low_pwr;
        logic power_down_flag;
        logic tmo;
        logic [PORT_W-1:0] wake_en;
        logic [PORT_W-1:0] pa_prev;
        logic [IRQ_NUM-1:0] irq_old;
        logic svc;
        pmw_osc_s osc;
        logic run;
        logic core_rst;
        logic pcsp_rst;
        logic wdt_clr;
        logic wdt_run;
        logic irq_svc;
        logic wait_req;
        logic [DATA_W-1:0] rdata;
    } pmw_state_s;

endpackage

// ### verilog/pmw_power_ctrl.sv
// Notes on behaviour
// R1: Crystal low-power select 0 means quick start, 1 means low-current mode.
// R2: Power-up clears the crystal low-power select bit.
// R3: Software should set low-power select about 2 s after power-on.
// R4: Slow crystal keeps running whatever the low-power select holds.
// R5: System clock select picks Normal (fast osc) or Slow (slow crystal).
// R6: System clock select acts only with fast RC plus slow crystal.
// R7: Slow crystal is unavailable with external fast crystal or RC.
// R8: Modes Normal, Slow, Idle, Sleep; fast clock stops in Slow and halt.
// R9: Halt enters Idle if slow crystal runs, else Sleep.
// R10: Sleep stops system oscillator and holds execution; state kept.
// R11: Halt clears watchdog; it stops only when clocked from system clock.
// R12: Halt sets power-down flag and clears time-out flag.
// R13: Configured slow crystal keeps running after halt; no enable used.
// R14: Slow RC keeps running when halted unless configured off.
// R15: Wake on external reset, port A fall, interrupt or watchdog overflow.
// R16: Reset wake is full reset; watchdog wake sets timeout, resets PC/SP.
// R17: Power-down flag cleared by power-up or clear-watchdog, set by halt.
// R18: Enabled port A falling edge wakes; execution resumes after halt.
// R19: Disabled or stack-full interrupt wake resumes; otherwise it is served.
// R20: Interrupt already pending before halt does not cause a wake-up.
// R21: Wake delay 2 clocks for RC, 128 for crystal; reset adds delay.
// R22: Reset wake waits power-on delay then the crystal start-up count.
// R23: Clock select 0 is fast RC, 1 is slow crystal with fast RC stopped.
// R24: Low-power select is bit 1, clock select bit 0 of control reg zero.
// R25: Start-up delay counted on the restarted clock; execution held.
module pmw_power_ctrl #(
    parameter int unsigned RSTD_CYCLES = pmw_pkg::RESET_DELAY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ext_resetn_i,
    input wire logic [1:0] osc_cfg_i,
    input wire logic [1:0] wdt_src_i,
    input wire logic slow_rc_disable_i,
    input wire pmw_pkg::pmw_core_s core_i,
    input wire logic wdt_overflow_i,
    input wire logic [pmw_pkg::PORT_W-1:0] port_a_i,
    input wire logic [pmw_pkg::IRQ_NUM-1:0] irq_req_i,
    input wire logic [pmw_pkg::IRQ_NUM-1:0] irq_en_i,
    input wire logic [pmw_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pmw_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [pmw_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output pmw_pkg::pmw_osc_s osc_o,
    output logic run_o,
    output logic core_reset_o,
    output logic pc_sp_reset_o,
    output logic wdt_clear_o,
    output logic wdt_run_o,
    output logic irq_service_o
);

    // ****************************************************************
    // State and derived terms
    // ****************************************************************
    pmw_pkg::pmw_state_s s_q;
    pmw_pkg::pmw_state_s s_d;
    logic xtal_cfg;
    logic slow_sel;
    logic crystal;
    logic halted;
    logic halted_d;
    logic wake_go;
    logic [pmw_pkg::PORT_W-1:0] pa_fall;
    logic [pmw_pkg::IRQ_NUM-1:0] irq_new;
    logic [pmw_pkg::CNT_W-1:0] sst_load;

    localparam logic [pmw_pkg::CNT_W-1:0] RSTD_LOAD =
        pmw_pkg::CNT_W'(RSTD_CYCLES - 1);
    localparam logic [pmw_pkg::CNT_W-1:0] SST1_LOAD =
        pmw_pkg::CNT_W'(pmw_pkg::SHORT_STARTUP_CYC - 1);
    localparam logic [pmw_pkg::CNT_W-1:0] SST2_LOAD =
        pmw_pkg::CNT_W'(pmw_pkg::LONG_STARTUP_CYC - 1);

    always_comb
    begin
        xtal_cfg = (osc_cfg_i == pmw_pkg::CFG_FAST_RC_SLOW_XTAL); // R6 R7
        slow_sel = s_q.clk_sel & xtal_cfg; // R6 R23
        crystal = (osc_cfg_i == pmw_pkg::CFG_FAST_XTAL) || slow_sel;
        sst_load = crystal ? SST2_LOAD : SST1_LOAD; // R21
        halted = (s_q.mode == pmw_pkg::MODE_IDLE)
            || (s_q.mode == pmw_pkg::MODE_SLEEP);
        pa_fall = s_q.pa_prev & ~port_a_i & s_q.wake_en; // R18
        // A request already pending at halt is masked out of the wake.
        irq_new = irq_req_i & ~s_q.irq_old; // R20
        wake_go = halted && (wdt_overflow_i || (|pa_fall) || (|irq_new));
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.pcsp_rst = 1'b0;
        s_d.wdt_clr = 1'b0;
        s_d.irq_svc = 1'b0;
        s_d.pa_prev = port_a_i;

        // Bus: one wait cycle, then the access completes.
        s_d.wait_req = !((avs_read || avs_write) && s_q.wait_req);
        if (avs_read && s_q.wait_req)
        begin
            s_d.rdata = '0;
            case (avs_address)
                pmw_pkg::CONTROL_REG_ZERO_OFS:
                begin
                    s_d.rdata[pmw_pkg::SYS_CLK_SEL_BIT] = s_q.clk_sel;
                    s_d.rdata[pmw_pkg::XTAL_LP_SEL_BIT] = s_q.low_pwr;
                end
                pmw_pkg::STATUS_OFS:
                begin
                    s_d.rdata[pmw_pkg::PDF_BIT] = s_q.power_down_flag;
                    s_d.rdata[pmw_pkg::TMO_BIT] = s_q.tmo;
                end
                pmw_pkg::PORT_A_WAKE_ENABLE_OFS:
                begin
                    s_d.rdata[pmw_pkg::PORT_W-1:0] = s_q.wake_en;
                end
                pmw_pkg::MODE_OFS:
                begin
                    s_d.rdata[4:0] = s_q.mode;
                    s_d.rdata[pmw_pkg::MODE_SLOW_BIT] = slow_sel;
                end
                default:
                begin
                    s_d.rdata = '0;
                end
            endcase
        end
        if (avs_write && !s_q.wait_req && avs_byteenable[0])
        begin
            case (avs_address)
                pmw_pkg::CONTROL_REG_ZERO_OFS:
                begin
                    // The crystal keeps running in either setting.
                    s_d.clk_sel =
                        avs_writedata[pmw_pkg::SYS_CLK_SEL_BIT]; // R5 R24
                    s_d.low_pwr =
                        avs_writedata[pmw_pkg::XTAL_LP_SEL_BIT]; // R1 R24
                end
                pmw_pkg::PORT_A_WAKE_ENABLE_OFS:
                begin
                    s_d.wake_en = avs_writedata[pmw_pkg::PORT_W-1:0];
                end
                default:
                begin
                    s_d.wake_en = s_q.wake_en;
                end
            endcase
        end

        // Flags: clears first so that a simultaneous set wins.
        if (core_i.clr_wdt)
        begin
            s_d.power_down_flag = 1'b0; // R17
        end
        if (core_i.halt && s_q.mode == pmw_pkg::MODE_RUN)
        begin
            s_d.power_down_flag = 1'b1; // R12 R17
            s_d.tmo = 1'b0; // R12
        end
        if (wdt_overflow_i)
        begin
            s_d.tmo = 1'b1; // R16
        end

        case (s_q.mode)
            pmw_pkg::MODE_RUN:
            begin
                if (core_i.halt)
                begin
                    // Clock select plays no part in the choice.
                    s_d.mode = xtal_cfg ? pmw_pkg::MODE_IDLE
                        : pmw_pkg::MODE_SLEEP; // R9
                    s_d.wdt_clr = 1'b1; // R11
                    s_d.irq_old = irq_req_i; // R20
                end
            end
            pmw_pkg::MODE_IDLE, pmw_pkg::MODE_SLEEP:
            begin
                if (wake_go) // R15
                begin
                    s_d.mode = pmw_pkg::MODE_WAKE;
                    s_d.cnt = sst_load; // R21 R25
                    s_d.pcsp_rst = wdt_overflow_i; // R16
                    s_d.svc = !wdt_overflow_i && (|(irq_new & irq_en_i))
                        && !core_i.stack_full; // R19
                end
            end
            pmw_pkg::MODE_WAKE:
            begin
                if (s_q.cnt == '0)
                begin
                    // Execution resumes after the halt instruction.
                    s_d.mode = pmw_pkg::MODE_RUN; // R18 R25
                    s_d.irq_svc = s_q.svc; // R19
                    s_d.svc = 1'b0;
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            pmw_pkg::MODE_RSTD:
            begin
                if (s_q.cnt == '0)
                begin
                    s_d.mode = pmw_pkg::MODE_WAKE;
                    s_d.cnt = SST2_LOAD; // R22
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            default:
            begin
                s_d.mode = pmw_pkg::MODE_RSTD;
                s_d.cnt = RSTD_LOAD;
            end
        endcase

        // The reset pin overrides the mode machine and holds the delay loaded.
        if (!ext_resetn_i)
        begin
            s_d.mode = pmw_pkg::MODE_RSTD; // R16 R21
            s_d.cnt = RSTD_LOAD; // R22
            s_d.pcsp_rst = 1'b0;
            s_d.svc = 1'b0;
        end

        halted_d = (s_d.mode == pmw_pkg::MODE_IDLE)
            || (s_d.mode == pmw_pkg::MODE_SLEEP);
        s_d.osc.fast_osc_run = !halted_d && !slow_sel; // R8 R10 R23
        s_d.osc.slow_xtal_run = xtal_cfg; // R4 R7 R13
        s_d.osc.slow_rc_run = !slow_rc_disable_i; // R14
        s_d.osc.sys_clk_slow = slow_sel; // R5
        s_d.osc.xtal_low_power = s_d.low_pwr; // R1
        s_d.wdt_run = !(halted_d
            && wdt_src_i == pmw_pkg::WDT_SRC_SYS); // R11
        s_d.run = (s_d.mode == pmw_pkg::MODE_RUN); // R10 R25
        s_d.core_rst = (s_d.mode == pmw_pkg::MODE_RSTD); // R16
    end

    // ****************************************************************
    // Register
    // ****************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            s_q <= '0;
            s_q.mode <= pmw_pkg::MODE_RSTD;
            s_q.cnt <= RSTD_LOAD;
            s_q.low_pwr <= 1'b0; // R2
            s_q.core_rst <= 1'b1;
            s_q.wait_req <= 1'b1;
            s_q.wdt_run <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.wait_req;
    assign osc_o = s_q.osc;
    assign run_o = s_q.run;
    assign core_reset_o = s_q.core_rst;
    assign pc_sp_reset_o = s_q.pcsp_rst;
    assign wdt_clear_o = s_q.wdt_clr;
    assign wdt_run_o = s_q.wdt_run;
    assign irq_service_o = s_q.irq_svc;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    logic halt_now;
    assign halt_now = core_i.halt && s_q.mode == pmw_pkg::MODE_RUN
        && ext_resetn_i;

    sequence rc_wait_s;
        (s_q.mode == pmw_pkg::MODE_WAKE) [*2]
            ##1 (s_q.mode == pmw_pkg::MODE_RUN);
    endsequence

    sequence xtal_wait_s;
        ##127 (s_q.mode == pmw_pkg::MODE_WAKE)
            ##1 (s_q.mode == pmw_pkg::MODE_RUN);
    endsequence

    halt_sets_pdf_a: assert property ( // R12
        halt_now && !wdt_overflow_i |=> s_q.power_down_flag && !s_q.tmo)
        else $error("halt did not set pdf and clear timeout");

    halt_mode_pick_a: assert property ( // R9
        halt_now |=> s_q.mode == (xtal_cfg ? pmw_pkg::MODE_IDLE
            : pmw_pkg::MODE_SLEEP) && !run_o && wdt_clear_o)
        else $error("halt entered the wrong mode");

    lp_powerup_a: assert property ( // R2
        $past(!resetn_i) |-> !osc_o.xtal_low_power && !s_q.low_pwr)
        else $error("low-power select not clear after power-up");

    clk_sel_gate_a: assert property ( // R6
        !xtal_cfg |=> !osc_o.sys_clk_slow)
        else $error("clock select acted outside fast rc plus crystal");

    xtal_runs_a: assert property ( // R13
        xtal_cfg |=> osc_o.slow_xtal_run)
        else $error("slow crystal stopped while configured");

    rc_wake_time_a: assert property ( // R21
        wake_go && !crystal && ext_resetn_i |=> rc_wait_s)
        else $error("rc wake delay not two clocks");

    xtal_wake_time_a: assert property ( // R21
        wake_go && crystal && ext_resetn_i |=> xtal_wait_s)
        else $error("crystal wake delay not 128 clocks");

    pdf_clear_a: assert property ( // R17
        core_i.clr_wdt && !halt_now |=> !s_q.power_down_flag)
        else $error("clear watchdog left pdf set");

    wdt_wake_a: assert property ( // R16
        halted && wdt_overflow_i && ext_resetn_i
            |=> s_q.tmo && pc_sp_reset_o ##1 !pc_sp_reset_o)
        else $error("watchdog wake did not set timeout and reset pc");

    wdt_gate_a: assert property ( // R11
        halted && ext_resetn_i && !wake_go
            && wdt_src_i == pmw_pkg::WDT_SRC_SYS |=> !wdt_run_o)
        else $error("system-clocked watchdog kept running in halt");

    stale_irq_a: assert property ( // R20
        halted && ext_resetn_i && !wdt_overflow_i && pa_fall == '0
            && (irq_req_i & ~s_q.irq_old) == '0 |=> halted)
        else $error("stale interrupt woke the device");

endmodule
